// ---- src/pmt_pkg.sv ----
// constants and types shared by the period match timer
`default_nettype none
package pmt_pkg;
  // apb geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNT_LOW = 8'h04;
  localparam logic [7:0] OFF_COUNT_HIGH_BUF = 8'h08;
  localparam logic [7:0] OFF_PERIOD_LOW = 8'h0c;
  localparam logic [7:0] OFF_PERIOD_HIGH = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // status field position
  localparam int unsigned STAT_FLAG_BIT = 0;
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // instruction cycle phases, one pclk each
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TCY_NS = 400;
  localparam int unsigned TCY_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // rising transition: oldest sample low, two newer high
  localparam logic [2:0] RISE_PATTERN = 3'h3;
  // prescaler terminal counts
  localparam logic [2:0] DIV1_LIMIT = 3'h0;
  localparam logic [2:0] DIV2_LIMIT = 3'h1;
  localparam logic [2:0] DIV4_LIMIT = 3'h3;
  localparam logic [2:0] DIV8_LIMIT = 3'h7;
  localparam logic [1:0] DIVSEL_2 = 2'h1;
  localparam logic [1:0] DIVSEL_4 = 2'h2;
  localparam logic [1:0] DIVSEL_8 = 2'h3;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic sleep_run_enable;
    logic trigger_reset_disable;
    logic one_shot_select;
    logic [1:0] input_divide_select;
    logic ext_sync_bypass;
    logic count_source_select;
    logic counter_run;
  } pmt_ctrl_t;

  // pulses from the input sampler
  typedef struct packed {
    logic sync_inc;
    logic async_edge;
  } pmt_edges_t;
endpackage : pmt_pkg
`default_nettype wire

// ---- src/pmt_edge_sampler.sv ----
// count input synchroniser with q2/q4 rise detector and raw edge detector
`default_nettype none
module pmt_edge_sampler (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // pin and phase
  input wire logic pin_in,
  input wire logic [1:0] phase,
  // detected events
  output var pmt_pkg::pmt_edges_t edges
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic [1:0] smp_q;
  logic pend_q;
  wire sample_now = (phase == pmt_pkg::PH_Q2) || (phase == pmt_pkg::PH_Q4);
  wire rise_seen = sample_now && ({smp_q, sync_q} == pmt_pkg::RISE_PATTERN);
  wire at_q1 = (phase == pmt_pkg::PH_Q1);

  // two-flop synchroniser and sample history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      smp_q <= 2'h0;
      pend_q <= 1'b0;
    end
    else if (ce)
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      if (sample_now)
        smp_q <= {smp_q[0], sync_q};
      if (rise_seen)
        pend_q <= 1'b1;
      else if (at_q1)
        pend_q <= 1'b0;
    end
  end

  // increment on the q1 after a decoded rise; unfiltered edge for the bypass path
  wire sync_inc_w = pend_q && at_q1 && ce;
  wire async_edge_w = sync_q && !prev_q && ce;
  assign edges = {sync_inc_w, async_edge_w};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rise;
    ce && rise_seen;
  endsequence
  a_rise_then_inc: assert property (s_rise |=> ##[0:3] (edges.sync_inc || !ce))
    else $error("decoded rise not counted on next q1");
  a_inc_on_q1: assert property (edges.sync_inc |-> phase == pmt_pkg::PH_Q1)
    else $error("synchronous increment off q1");
endmodule : pmt_edge_sampler
`default_nettype wire

// ---- src/pmt_timer.sv ----
// sixteen bit period match timer with apb register access
//
// Local design decisions: the address map and the APB interface to the registers.
`default_nettype none
module pmt_timer #(
  parameter int unsigned ADDR_W = pmt_pkg::ADDR_W
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [pmt_pkg::DATA_W-1:0] pwdata,
  output logic [pmt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // system and pin
  input wire logic sleep_active,
  input wire logic ext_count_input,
  // status out
  output logic period_match_flag
);
  pmt_pkg::pmt_ctrl_t ctrl_q;
  logic [15:0] count_q;
  logic [7:0] high_buf_q;
  logic [15:0] period_q;
  logic flag_q;
  logic [2:0] presc_q;
  logic [1:0] phase_q;
  logic [pmt_pkg::DATA_W-1:0] prdata_q;
  pmt_pkg::pmt_edges_t edges;

  // input pin sampler
  pmt_edge_sampler u_sampler (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_in(ext_count_input),
    .phase(phase_q),
    .edges(edges)
  );

  // address decode
  wire [7:0] addr8 = 8'(paddr);
  wire hit_ctrl = (addr8 == pmt_pkg::OFF_CONTROL);
  wire hit_low = (addr8 == pmt_pkg::OFF_COUNT_LOW);
  wire hit_hbuf = (addr8 == pmt_pkg::OFF_COUNT_HIGH_BUF);
  wire hit_perl = (addr8 == pmt_pkg::OFF_PERIOD_LOW);
  wire hit_perh = (addr8 == pmt_pkg::OFF_PERIOD_HIGH);
  wire hit_stat = (addr8 == pmt_pkg::OFF_STATUS);
  wire hit_any = hit_ctrl || hit_low || hit_hbuf || hit_perl || hit_perh || hit_stat;
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire wr_ok = access_ph && pwrite && hit_any && ce;
  wire ctrl_wr = wr_ok && hit_ctrl;
  wire low_wr = wr_ok && hit_low;
  wire hbuf_wr = wr_ok && hit_hbuf;
  wire perl_wr = wr_ok && hit_perl;
  wire perh_wr = wr_ok && hit_perh;
  wire stat_wr = wr_ok && hit_stat;
  // read snapshot taken in setup so buffer and data agree
  wire low_rd_snap = setup_ph && !pwrite && hit_low && ce;

  // sleep gating: only the unsynchronised pin path survives sleep
  wire sleep_ok = ctrl_q.sleep_run_enable && ctrl_q.count_source_select && ctrl_q.ext_sync_bypass;
  wire run_eff = ctrl_q.counter_run && (!sleep_active || sleep_ok);

  // count source select
  wire int_tick = (phase_q == pmt_pkg::PH_Q1);
  wire ext_tick = ctrl_q.ext_sync_bypass ? edges.async_edge : edges.sync_inc;
  wire src_tick = ce && (ctrl_q.count_source_select ? ext_tick : int_tick);

  // prescaler terminal count
  wire [2:0] presc_limit = (ctrl_q.input_divide_select == pmt_pkg::DIVSEL_8) ? pmt_pkg::DIV8_LIMIT :
                           (ctrl_q.input_divide_select == pmt_pkg::DIVSEL_4) ? pmt_pkg::DIV4_LIMIT :
                           (ctrl_q.input_divide_select == pmt_pkg::DIVSEL_2) ? pmt_pkg::DIV2_LIMIT :
                           pmt_pkg::DIV1_LIMIT;
  wire presc_clr = low_wr || !ctrl_q.counter_run;
  wire count_tick = run_eff && src_tick && (presc_q == presc_limit);
  wire at_match = (count_q == period_q);
  wire at_ones = (count_q == pmt_pkg::COUNT_ALL_ONES);
  wire wrap_evt = count_tick && (at_match || (at_ones && !ctrl_q.one_shot_select));

  // instruction cycle phase counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_q <= pmt_pkg::PH_Q1;
    else if (ce)
      phase_q <= 2'(phase_q + 2'h1);
  end

  // prescaler
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc_q <= pmt_pkg::DIV1_LIMIT;
    else if (ce)
    begin
      if (presc_clr)
        presc_q <= pmt_pkg::DIV1_LIMIT;
      else if (run_eff && src_tick)
        presc_q <= (presc_q == presc_limit) ? pmt_pkg::DIV1_LIMIT : 3'(presc_q + 3'h1);
    end
  end

  // count pair: bus write beats tick, stopped count holds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= pmt_pkg::COUNT_RESET;
    else if (ce)
    begin
      if (low_wr)
        count_q <= {high_buf_q, pwdata[7:0]};
      else if (wrap_evt)
        count_q <= pmt_pkg::COUNT_RESET;
      else if (count_tick)
        count_q <= 16'(count_q + 16'h0001);
    end
  end

  // high byte buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      high_buf_q <= pmt_pkg::BYTE_ZERO;
    else if (ce)
    begin
      if (hbuf_wr)
        high_buf_q <= pwdata[7:0];
      else if (low_rd_snap)
        high_buf_q <= count_q[15:8];
    end
  end

  // period pair, writable at any time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      period_q <= pmt_pkg::PERIOD_RESET;
    else if (ce)
    begin
      if (perl_wr)
        period_q[7:0] <= pwdata[7:0];
      if (perh_wr)
        period_q[15:8] <= pwdata[7:0];
    end
  end

  // control; a same-cycle software write wins over the hardware halt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= pmt_pkg::CONTROL_RESET;
    else if (ce)
    begin
      if (ctrl_wr)
        ctrl_q <= pwdata[7:0];
      else if (wrap_evt && ctrl_q.one_shot_select)
        ctrl_q.counter_run <= 1'b0;
    end
  end

  // match flag, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= 1'b0;
    else if (ce)
    begin
      if (wrap_evt)
        flag_q <= 1'b1;
      else if (stat_wr && pwdata[pmt_pkg::STAT_FLAG_BIT])
        flag_q <= 1'b0;
    end
  end

  // read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= '0;
    else if (ce && setup_ph && !pwrite)
    begin
      prdata_q <= '0;
      if (hit_ctrl)
        prdata_q[7:0] <= ctrl_q;
      if (hit_low)
        prdata_q[7:0] <= count_q[7:0];
      if (hit_hbuf)
        prdata_q[7:0] <= high_buf_q;
      if (hit_perl)
        prdata_q[7:0] <= period_q[7:0];
      if (hit_perh)
        prdata_q[7:0] <= period_q[15:8];
      if (hit_stat)
        prdata_q[pmt_pkg::STAT_FLAG_BIT] <= flag_q;
    end
  end

  // bus answers: zero wait states while ce is high, error on unmapped
  assign pready = ce;
  assign pslverr = access_ph && !hit_any;
  assign prdata = prdata_q;
  assign period_match_flag = flag_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_stop_holds_count: assert property (ce && !run_eff && !low_wr |=> count_q == $past(count_q))
    else $error("count moved while stopped");
  a_sleep_gates_tick: assert property (sleep_active && !sleep_ok |-> !count_tick)
    else $error("count advanced in sleep without bypass path");
  a_match_rolls_zero: assert property (ce && count_tick && at_match && !low_wr |=> count_q == 16'h0000 && flag_q)
    else $error("period match did not roll over and flag");
  a_int_tick_q1: assert property (count_tick && !ctrl_q.count_source_select |-> phase_q == pmt_pkg::PH_Q1)
    else $error("internal count off first phase");
  a_tick_at_limit: assert property (count_tick |-> presc_q == presc_limit)
    else $error("count advanced before prescaler terminal");
  a_div2_spacing: assert property (ce && count_tick && !ctrl_q.count_source_select
                                   && ctrl_q.input_divide_select == pmt_pkg::DIVSEL_2 && !ctrl_wr
                                   |=> !count_tick [*7])
    else $error("divide by two ticked too early");
  a_one_shot_halt: assert property (ce && wrap_evt && ctrl_q.one_shot_select && !ctrl_wr |=> !ctrl_q.counter_run)
    else $error("single shot did not halt");
  a_cont_keeps_run: assert property (ce && wrap_evt && !ctrl_q.one_shot_select && !ctrl_wr
                                     |=> ctrl_q.counter_run && flag_q)
    else $error("continuous mode lost run or flag");
  a_low_write_pair: assert property (low_wr |=> count_q == {$past(high_buf_q), $past(pwdata[7:0])})
    else $error("low write did not load whole pair");
  a_low_read_buf: assert property (low_rd_snap && !hbuf_wr |=> high_buf_q == $past(count_q[15:8]))
    else $error("low read did not load buffer");
  a_presc_cleared: assert property (ce && presc_clr |=> presc_q == 3'h0)
    else $error("prescaler not cleared");
  a_period_write: assert property (perl_wr |=> period_q[7:0] == $past(pwdata[7:0]))
    else $error("period write refused");
  a_ext_bypass: assert property (count_tick && ctrl_q.count_source_select && ctrl_q.ext_sync_bypass
                                 |-> edges.async_edge)
    else $error("bypass count without pin edge");

  // all-ones tick that is not a period match
  sequence s_ones_tick;
    ce && count_tick && at_ones && !at_match && !low_wr;
  endsequence
  // control write landing between source ticks of a running timer
  sequence s_ctrl_mid_run;
    ctrl_wr && ctrl_q.counter_run && !(run_eff && src_tick);
  endsequence
  // count taken from the synchronised pin path
  sequence s_pin_sync_tick;
    count_tick && ctrl_q.count_source_select && !ctrl_q.ext_sync_bypass;
  endsequence

  // rollover past all ones in continuous mode
  a_ones_rollover: assert property (s_ones_tick ##0 !ctrl_q.one_shot_select
                                    |=> count_q == pmt_pkg::COUNT_RESET && flag_q)
    else $error("all-ones rollover did not clear and flag");
  // control writes keep the prescaler
  a_ctrl_keeps_presc: assert property (s_ctrl_mid_run |=> presc_q == $past(presc_q))
    else $error("control write disturbed the prescaler");
  // synchronised pin counts only on a decoded rise
  a_sync_pin_tick: assert property (s_pin_sync_tick |-> edges.sync_inc)
    else $error("synchronised count without decoded rise");
  // stored control bits, trigger-reset disable included
  a_ctrl_write_lands: assert property (ctrl_wr |=> ctrl_q == $past(pwdata[7:0]))
    else $error("control write not stored");
  // buffer writes alone never move the count
  a_hbuf_keeps_count: assert property (hbuf_wr && !count_tick |=> count_q == $past(count_q))
    else $error("buffer write changed the count");
  // period high byte accepted at any time
  a_period_high_write: assert property (perh_wr |=> period_q[15:8] == $past(pwdata[7:0]))
    else $error("period high write refused");

  // clock enable low freezes the timer state
  a_ce_freeze: assert property (!ce |=> count_q == $past(count_q) && presc_q == $past(presc_q)
                                && phase_q == $past(phase_q) && flag_q == $past(flag_q))
    else $error("state moved with clock enable low");
endmodule : pmt_timer
`default_nettype wire

// ---- tb/pmt_pulse_src.sv ----
// external pulse source model driving the count input pin
`default_nettype none
module pmt_pulse_src (
  // clock
  input wire logic pclk,
  // request
  input wire logic go,
  input wire logic [7:0] pulses,
  // pin and status
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int n;
  logic pin_q = 1'b0;
  logic busy_q = 1'b0;
  // single driver for each output
  assign pin = pin_q;
  assign busy = busy_q;
  // two instruction cycles high and low per pulse, pin idles low
  always @(posedge pclk)
    if (go && !busy_q)
    begin
      busy_q <= 1'b1;
      n = pulses;
      repeat (n)
      begin
        repeat (8) @(posedge pclk);
        pin_q <= 1'b1;
        repeat (8) @(posedge pclk);
        pin_q <= 1'b0;
      end
      repeat (8) @(posedge pclk);
      busy_q <= 1'b0;
    end
endmodule : pmt_pulse_src
`default_nettype wire

// ---- tb/pmt_timer_test.sv ----
// self-checking bench for the period match timer
`default_nettype none
module pmt_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic err;} pmt_row_t;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, sleep_active = 1'b0, pin, flag, go = 1'b0, busy, e;
  logic [7:0] pulses = 8'h00, v;
  int failures = 0, check_count = 0, cycles = 0;
  pmt_row_t rows [6] = '{'{pmt_pkg::OFF_CONTROL, 8'hfe, 8'hfe, 1'b0},
    '{pmt_pkg::OFF_CONTROL, 8'h00, 8'h00, 1'b0}, '{pmt_pkg::OFF_PERIOD_LOW, 8'h34, 8'h34, 1'b0},
    '{pmt_pkg::OFF_PERIOD_HIGH, 8'h12, 8'h12, 1'b0}, '{pmt_pkg::OFF_COUNT_HIGH_BUF, 8'h5a, 8'h5a, 1'b0},
    '{8'h18, 8'ha5, 8'h00, 1'b1}};
  // design and far-side source
  pmt_timer i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_active(sleep_active), .ext_count_input(pin), .period_match_flag(flag));
  pmt_pulse_src i_src (.pclk(pclk), .go(go), .pulses(pulses), .pin(pin), .busy(busy));
  always #50 pclk = ~pclk;
  // hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rc(input logic [7:0] a, input logic [7:0] x, input string m);
    apb(1'b0, a, 8'h00);
    chk(r === {24'h0, x}, m);
  endtask : rc
  // clear the count with a buffered pair write
  task automatic zc();
    apb(1'b1, pmt_pkg::OFF_COUNT_HIGH_BUF, 8'h00);
    apb(1'b1, pmt_pkg::OFF_COUNT_LOW, 8'h00);
  endtask : zc
  task automatic send(input logic [7:0] n);
    pulses <= n;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy !== 1'b0) @(posedge pclk);
  endtask : send
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rc(pmt_pkg::OFF_CONTROL, 8'h00, "control reset");
    rc(pmt_pkg::OFF_PERIOD_LOW, 8'hff, "period reset");
    chk(flag === 1'b0, "flag reset");
    // register table rows
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk(e === rows[i].err, "write response");
      rc(rows[i].a, rows[i].e, "readback");
      chk(e === rows[i].err, "read response");
    end
    // buffered 16-bit write and read
    apb(1'b1, pmt_pkg::OFF_COUNT_HIGH_BUF, 8'hab);
    apb(1'b1, pmt_pkg::OFF_COUNT_LOW, 8'hcd);
    apb(1'b1, pmt_pkg::OFF_COUNT_HIGH_BUF, 8'h77);
    rc(pmt_pkg::OFF_COUNT_LOW, 8'hcd, "low byte");
    rc(pmt_pkg::OFF_COUNT_HIGH_BUF, 8'hab, "high via buffer");
    // internal clock through each divider setting
    apb(1'b1, pmt_pkg::OFF_PERIOD_LOW, 8'hff);
    apb(1'b1, pmt_pkg::OFF_PERIOD_HIGH, 8'hff);
    for (int c = 0; c < 4; c++)
    begin
      zc();
      apb(1'b1, pmt_pkg::OFF_CONTROL, {3'h0, c[1:0], 3'h1});
      repeat (40 * (1 << c) - 2) @(posedge pclk);
      apb(1'b1, pmt_pkg::OFF_CONTROL, 8'h00);
      apb(1'b0, pmt_pkg::OFF_COUNT_LOW, 8'h00);
      v = r[7:0];
      chk(v >= 8'h09 && v <= 8'h0b, "divided tick count");
      repeat (40) @(posedge pclk);
      rc(pmt_pkg::OFF_COUNT_LOW, v, "count held when stopped");
    end
    // continuous match with period changed while running
    zc();
    apb(1'b1, pmt_pkg::OFF_CONTROL, 8'h01);
    apb(1'b1, pmt_pkg::OFF_PERIOD_LOW, 8'h05);
    apb(1'b1, pmt_pkg::OFF_PERIOD_HIGH, 8'h00);
    repeat (40) @(posedge pclk);
    rc(pmt_pkg::OFF_CONTROL, 8'h01, "continuous keeps run");
    apb(1'b1, pmt_pkg::OFF_CONTROL, 8'h00);
    chk(flag === 1'b1, "match flag set");
    apb(1'b0, pmt_pkg::OFF_COUNT_LOW, 8'h00);
    chk(r[7:0] <= 8'h05, "count rolled to zero");
    apb(1'b1, pmt_pkg::OFF_STATUS, 8'h01);
    @(negedge pclk);
    chk(flag === 1'b0, "flag cleared");
    // single-shot halts itself
    apb(1'b1, pmt_pkg::OFF_PERIOD_LOW, 8'h03);
    zc();
    apb(1'b1, pmt_pkg::OFF_CONTROL, 8'h21);
    repeat (40) @(posedge pclk);
    rc(pmt_pkg::OFF_CONTROL, 8'h20, "single-shot clears run");
    rc(pmt_pkg::OFF_COUNT_LOW, 8'h00, "single-shot count cleared");
    chk(flag === 1'b1, "single-shot flag");
    // continuous rollover from all ones with the count above the period
    apb(1'b1, pmt_pkg::OFF_STATUS, 8'h01);
    apb(1'b1, pmt_pkg::OFF_COUNT_HIGH_BUF, 8'hff);
    apb(1'b1, pmt_pkg::OFF_COUNT_LOW, 8'hfd);
    apb(1'b1, pmt_pkg::OFF_CONTROL, 8'h01);
    repeat (20) @(posedge pclk);
    apb(1'b1, pmt_pkg::OFF_CONTROL, 8'h00);
    chk(flag === 1'b1, "all-ones rollover flag");
    apb(1'b0, pmt_pkg::OFF_COUNT_LOW, 8'h00);
    chk(r[7:0] <= 8'h03, "rollover count restarted");
    rc(pmt_pkg::OFF_COUNT_HIGH_BUF, 8'h00, "rollover high byte");
    apb(1'b1, pmt_pkg::OFF_PERIOD_LOW, 8'hff);
    // pin counting, synchronised then bypassed
    for (int b = 0; b < 2; b++)
    begin
      zc();
      apb(1'b1, pmt_pkg::OFF_CONTROL, {5'h0, b[0], 2'h3});
      send(8'h05);
      rc(pmt_pkg::OFF_COUNT_LOW, 8'h05, "pin pulses counted");
    end
    // sleep stops the timer unless enabled with bypassed pin
    sleep_active <= 1'b1;
    zc();
    apb(1'b1, pmt_pkg::OFF_CONTROL, 8'h01);
    repeat (40) @(posedge pclk);
    rc(pmt_pkg::OFF_COUNT_LOW, 8'h00, "sleep halts count");
    apb(1'b1, pmt_pkg::OFF_CONTROL, 8'h87);
    send(8'h04);
    rc(pmt_pkg::OFF_COUNT_LOW, 8'h04, "sleep run enabled");
    sleep_active <= 1'b0;
    // clock enable low freezes counting and holds off the bus
    zc();
    apb(1'b1, pmt_pkg::OFF_CONTROL, 8'h01);
    ce <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(pready === 1'b0, "ready with clock enable low");
    ce <= 1'b1;
    apb(1'b1, pmt_pkg::OFF_CONTROL, 8'h00);
    apb(1'b0, pmt_pkg::OFF_COUNT_LOW, 8'h00);
    chk(r[7:0] <= 8'h01, "count moved with clock enable low");
    // reset in mid-run returns the registers to their reset values
    apb(1'b1, pmt_pkg::OFF_PERIOD_LOW, 8'h12);
    apb(1'b1, pmt_pkg::OFF_CONTROL, 8'h61);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(flag === 1'b0, "flag after reset");
    rc(pmt_pkg::OFF_CONTROL, 8'h00, "control after reset");
    rc(pmt_pkg::OFF_COUNT_LOW, 8'h00, "count after reset");
    rc(pmt_pkg::OFF_PERIOD_LOW, 8'hff, "period after reset");
    end_sim();
  end
endmodule : pmt_timer_test
`default_nettype wire
